/* rtl/dsa_params.svh */
// constants for the dual-slope converter sequencer
`ifndef DSA_PARAMS_SVH
`define DSA_PARAMS_SVH

// ----------------------------------------------------------------
// counter landmarks, five packed bcd digits
// ----------------------------------------------------------------
`define DSA_CNT_ZERO 20'h0_0000
`define DSA_CNT_HOLD 20'h2_0000
`define DSA_CNT_OVER 20'h2_0000
`define DSA_CNT_AZ_END 20'h3_0000
`define DSA_CNT_IN_LAST 20'h3_9999
`define DSA_BCD_NINE 4'h9
`define DSA_BCD_ZERO 4'h0
`define DSA_BCD_ONE 4'h1
`define DSA_BCD_BLANK 4'hF

// ----------------------------------------------------------------
// timing in oscillator (core clock) cycles
// ----------------------------------------------------------------
`define DSA_HOLD_PULSES 16'h0FA0
`define DSA_SCAN_DIV 16'h0190

// ----------------------------------------------------------------
// display layout and reset values
// ----------------------------------------------------------------
`define DSA_NUM_DIGITS 5
`define DSA_MSD_POS 3'h4
`define DSA_POS_FIRST 3'h0
`define DSA_EN_FIRST 5'h01
`define DSA_SEG_BLANK 7'h00
`define DSA_CTRL_AZ 2'h0
`define DSA_CTRL_IN 2'h3
`define DSA_SYNC_RST 3'h7

`endif

/* rtl/dsa_pkg.sv */
// types shared by the sequencer and the digit scanner
package dsa_pkg;

    // ------------------------------------------------------------
    // conversion phases
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_AZ,
        PH_HOLD,
        PH_INT_IN,
        PH_INT_REF
    } dsa_phase_t;

    // ------------------------------------------------------------
    // latched result: half digit plus four bcd digits
    // ------------------------------------------------------------
    typedef struct packed {
        logic half;
        logic [3:0][3:0] dig;
    } dsa_result_t;

    // phase-select lines to the analog front end
    typedef struct packed {
        logic a;
        logic b;
    } dsa_ctrl_t;

endpackage : dsa_pkg

/* rtl/dsa_digit_scan.sv */
// result register and multiplexed digit scanner
`include "dsa_params.svh"

module dsa_digit_scan
    import dsa_pkg::*;
#(
    parameter int unsigned SCAN_DIV = `DSA_SCAN_DIV
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // result load from the sequencer
    input wire logic load_i,
    input wire logic clear_i,
    input wire dsa_result_t result_i,
    input wire logic sign_i,
    input wire logic over_i,
    input wire logic fmt_bcd_i,
    // display side
    output logic [`DSA_NUM_DIGITS-1:0] digit_en_o,
    output logic [6:0] code_o,
    output logic sign_o
);

    localparam int DW = $clog2(SCAN_DIV);
    localparam logic [DW-1:0] DIV_LAST = DW'(SCAN_DIV - 1);

    dsa_result_t res;
    logic res_sign;
    logic res_over;
    logic [DW-1:0] div;
    logic [2:0] pos;
    logic [3:0] next_nib;
    logic next_blank;

    // seven-segment code, bit order gfedcba, active high
    function automatic logic [6:0] seg_of(input logic [3:0] d);
        case (d)
            4'h0: seg_of = 7'h3F;
            4'h1: seg_of = 7'h06;
            4'h2: seg_of = 7'h5B;
            4'h3: seg_of = 7'h4F;
            4'h4: seg_of = 7'h66;
            4'h5: seg_of = 7'h6D;
            4'h6: seg_of = 7'h7D;
            4'h7: seg_of = 7'h07;
            4'h8: seg_of = 7'h7F;
            4'h9: seg_of = 7'h6F;
            default: seg_of = `DSA_SEG_BLANK;
        endcase
    endfunction : seg_of

    // ------------------------------------------------------------
    // result register, one strobe loads all seventeen result bits with sign and over-range
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            res <= '0;
            res_sign <= 1'b0;
            res_over <= 1'b0;
        end else if (clear_i) begin
            res <= '0;
            res_sign <= 1'b0;
            res_over <= 1'b0;
        end else if (load_i) begin
            res <= result_i;
            res_sign <= sign_i;
            res_over <= over_i;
        end
    end

    // ------------------------------------------------------------
    // scan divider and position, free running in every phase
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div <= '0;
            pos <= `DSA_POS_FIRST;
        end else if (div == DIV_LAST) begin
            div <= '0;
            pos <= (pos == `DSA_MSD_POS) ? `DSA_POS_FIRST : pos + 3'h1;
        end else begin
            div <= div + DW'(1);
        end
    end

    // nibble for the current position, with over-range blanking
    always_comb begin
        next_nib = (pos == `DSA_MSD_POS) ?
            (res.half ? `DSA_BCD_ONE : `DSA_BCD_ZERO) : res.dig[pos[1:0]];
        next_blank = res_over && (pos != `DSA_MSD_POS);
        if (next_blank) begin
            next_nib = `DSA_BCD_BLANK;
        end
    end

    // ------------------------------------------------------------
    // registered outputs: code and enable change together
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            digit_en_o <= '0;
            code_o <= `DSA_SEG_BLANK;
            sign_o <= 1'b0;
        end else begin
            digit_en_o <= `DSA_NUM_DIGITS'(1) << pos;
            code_o <= fmt_bcd_i ? {3'h0, next_nib} : seg_of(next_nib);
            sign_o <= res_sign && (pos == `DSA_MSD_POS);
        end
    end

    chk_scan_onehot: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) $past(rst_n_i) |-> $onehot(digit_en_o))
        else $error("digit enable not one-hot");

    chk_scan_step: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (digit_en_o != $past(digit_en_o)) && $past(rst_n_i, 2)
        |-> $past(div, 2) == DIV_LAST)
        else $error("digit advanced off the scan divider");

    chk_over_blank: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        $past(res_over) && $past(pos) != `DSA_MSD_POS && !$past(fmt_bcd_i)
        |-> code_o == `DSA_SEG_BLANK)
        else $error("low digit shown during over-range");

endmodule : dsa_digit_scan

/* rtl/dsa_sequencer.sv */
// dual-slope converter sequencer: counter, phase control, display
`include "dsa_params.svh"

module dsa_sequencer
    import dsa_pkg::*;
#(
    parameter int unsigned HOLD_PULSES = `DSA_HOLD_PULSES,
    parameter int unsigned SCAN_DIV = `DSA_SCAN_DIV
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // pins from outside the clock domain
    input wire logic trigger_i,
    input wire logic comparator_i,
    input wire logic fmt_bcd_i,
    // analog front end controls
    output logic ctrl_a_o,
    output logic ctrl_b_o,
    // status
    output logic over_range_o,
    output logic result_strobe_o,
    output logic hold_o,
    // display
    output logic [`DSA_NUM_DIGITS-1:0] digit_en_o,
    output logic [6:0] code_o,
    output logic sign_o
);

    localparam int HW = $clog2(HOLD_PULSES);
    localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_PULSES - 1);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] filt;
    logic trig;
    logic cmp;
    logic fmt;
    logic pre;
    logic tick;
    logic [19:0] cnt;
    dsa_phase_t phase;
    dsa_ctrl_t ctrl;
    logic pol;
    logic [HW-1:0] hold_tmr;
    logic load;
    logic clear;
    logic over;
    dsa_result_t next_result;

    // next bcd value, wrapping from 39999 back to zero
    function automatic logic [19:0] bcd_inc(input logic [19:0] v);
        logic [19:0] r;
        logic carry;
        r = v;
        carry = 1'b1;
        if (v == `DSA_CNT_IN_LAST) begin
            r = `DSA_CNT_ZERO;
        end else begin
            for (int i = 0; i < `DSA_NUM_DIGITS; i++) begin
                if (carry) begin
                    if (v[i*4 +: 4] == `DSA_BCD_NINE) begin
                        r[i*4 +: 4] = `DSA_BCD_ZERO;
                    end else begin
                        r[i*4 +: 4] = v[i*4 +: 4] + 4'h1;
                        carry = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction : bcd_inc

    // ------------------------------------------------------------
    // pin synchronisers: a change counts once stages two and three agree
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1 <= `DSA_SYNC_RST;
            sync2 <= `DSA_SYNC_RST;
            sync3 <= `DSA_SYNC_RST;
            filt <= `DSA_SYNC_RST;
        end else begin
            sync1 <= {fmt_bcd_i, comparator_i, trigger_i};
            sync2 <= sync1;
            sync3 <= sync2;
            filt <= (sync3 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
        end
    end

    assign trig = filt[0];
    assign cmp = filt[1];
    assign fmt = filt[2];

    // ------------------------------------------------------------
    // count prescaler: one tick every two clocks
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre <= 1'b0;
        end else begin
            pre <= ~pre;
        end
    end

    assign tick = pre;

    // ------------------------------------------------------------
    // hold timer, samples the trigger every HOLD_PULSES clocks
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_tmr <= '0;
        end else if (phase != PH_HOLD || hold_tmr == HOLD_LAST) begin
            hold_tmr <= '0;
        end else begin
            hold_tmr <= hold_tmr + HW'(1);
        end
    end

    // result digits taken from the counter
    always_comb begin
        next_result.dig = cnt[15:0];
        next_result.half = (cnt[19:16] != `DSA_BCD_ZERO);
    end

    // ------------------------------------------------------------
    // phase sequencer, counter and control lines
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase <= PH_AZ;
            cnt <= `DSA_CNT_ZERO;
            ctrl <= `DSA_CTRL_AZ;
            pol <= 1'b0;
            over <= 1'b0;
            load <= 1'b0;
            clear <= 1'b0;
        end else begin
            load <= 1'b0;
            clear <= 1'b0;
            case (phase)
                PH_AZ: begin
                    // comparator oscillates here and is not looked at
                    if (tick) begin
                        if (cnt == `DSA_CNT_HOLD && !trig) begin
                            phase <= PH_HOLD;
                        end else if (bcd_inc(cnt) == `DSA_CNT_AZ_END) begin
                            phase <= PH_INT_IN;
                            ctrl <= `DSA_CTRL_IN;
                            cnt <= bcd_inc(cnt);
                        end else begin
                            cnt <= bcd_inc(cnt);
                        end
                    end
                end
                PH_HOLD: begin
                    if (hold_tmr == HOLD_LAST && trig) begin
                        phase <= PH_AZ;
                        if (cmp) begin
                            cnt <= `DSA_CNT_ZERO;
                            clear <= 1'b1;
                            over <= 1'b0;
                        end
                    end
                end
                PH_INT_IN: begin
                    // fixed length: 30000 through 39999
                    if (tick) begin
                        cnt <= bcd_inc(cnt);
                        if (cnt == `DSA_CNT_IN_LAST) begin
                            phase <= PH_INT_REF;
                            pol <= cmp;
                            ctrl.a <= cmp;
                            ctrl.b <= ~cmp;
                        end
                    end
                end
                PH_INT_REF: begin
                    if (tick) begin
                        if (cmp != pol) begin
                            phase <= PH_AZ;
                            ctrl <= `DSA_CTRL_AZ;
                            load <= 1'b1;
                            over <= 1'b0;
                            cnt <= bcd_inc(cnt);
                        end else if (cnt == `DSA_CNT_OVER) begin
                            phase <= PH_AZ;
                            ctrl <= `DSA_CTRL_AZ;
                            load <= 1'b1;
                            over <= 1'b1;
                        end else begin
                            cnt <= bcd_inc(cnt);
                        end
                    end
                end
                default: begin
                    phase <= PH_AZ;
                    ctrl <= `DSA_CTRL_AZ;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            result_strobe_o <= 1'b0;
            over_range_o <= 1'b0;
            hold_o <= 1'b0;
        end else begin
            result_strobe_o <= load;
            over_range_o <= over;
            hold_o <= (phase == PH_HOLD);
        end
    end

    assign ctrl_a_o = ctrl.a;
    assign ctrl_b_o = ctrl.b;

    // ------------------------------------------------------------
    // result register and display scanner
    // ------------------------------------------------------------
    dsa_digit_scan #(
        .SCAN_DIV(SCAN_DIV)
    ) u_scan (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .load_i(load),
        .clear_i(clear),
        .result_i(next_result),
        .sign_i(pol),
        .over_i(over),
        .fmt_bcd_i(fmt),
        .digit_en_o(digit_en_o),
        .code_o(code_o),
        .sign_o(sign_o)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_tick_rate: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (cnt != $past(cnt)) && (phase != PH_AZ || $past(phase) != PH_HOLD)
        |-> $past(tick))
        else $error("counter moved off a count tick");

    chk_az_ctrl_low: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (phase == PH_AZ || phase == PH_HOLD) |-> ctrl == `DSA_CTRL_AZ)
        else $error("controls not low in auto-zero");

    chk_hold_entry: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        tick && phase == PH_AZ && cnt == `DSA_CNT_HOLD && !trig
        |=> phase == PH_HOLD ##1 cnt == `DSA_CNT_HOLD)
        else $error("hold not entered at 20000");

    chk_hold_frozen: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        phase == PH_HOLD && !(hold_tmr == HOLD_LAST && trig)
        |=> phase == PH_HOLD && $stable(cnt))
        else $error("hold left without a trigger test");

    chk_int_in_start: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        $rose(phase == PH_INT_IN)
        |-> cnt == `DSA_CNT_AZ_END && ctrl == `DSA_CTRL_IN)
        else $error("integrate-input started off 30000");

    chk_ref_start: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        $rose(phase == PH_INT_REF)
        |-> cnt == `DSA_CNT_ZERO && $past(cnt) == `DSA_CNT_IN_LAST)
        else $error("reference phase not begun at rollover");

    chk_ref_polarity: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        phase == PH_INT_REF |-> ctrl.a == pol && ctrl.b == !pol)
        else $error("reference controls disagree with polarity");

    chk_over_range: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        tick && phase == PH_INT_REF && cnt == `DSA_CNT_OVER && cmp == pol
        |=> phase == PH_AZ ##1 over_range_o && result_strobe_o)
        else $error("over-range not flagged at 20000");

    chk_strobe_cause: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        result_strobe_o |-> $past(phase, 2) == PH_INT_REF)
        else $error("result loaded outside integrate-reference");

endmodule : dsa_sequencer

/* test/dsa_fe_model.sv */
// behavioural analog front end: integrator and zero-crossing comparator
module dsa_fe_model (
    // clock and phase controls from the sequencer
    input wire logic core_clk_i,
    input wire logic ctrl_a_i,
    input wire logic ctrl_b_i,
    // scenario settings
    input wire logic positive_i,
    input wire logic osc_en_i,
    input wire logic [15:0] ref_clocks_i,
    // comparator pin
    output logic comparator_o
);
    timeunit 1ns;
    timeprecision 1ns;

    int n = 0;

    initial comparator_o = 1'b0;

    // comparator follows the integrator, changed just after each edge
    always @(posedge core_clk_i) begin
        #1;
        if (ctrl_a_i && ctrl_b_i) begin
            // input integration: sign of the input shows at once
            n = 0;
            comparator_o = positive_i;
        end else if (ctrl_a_i != ctrl_b_i) begin
            // reference ramps back, crossing after ref_clocks_i clocks
            n = n + 1;
            comparator_o = (n < ref_clocks_i) ? positive_i : !positive_i;
        end else begin
            // limit cycle in auto-zero: toggles each clock when enabled
            comparator_o = osc_en_i ? !comparator_o : 1'b0;
        end
    end
endmodule : dsa_fe_model

/* test/tb.sv */
// self-checking bench for the dual-slope converter sequencer
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import dsa_pkg::*;

    // ------------------------------------------------------------
    // signals and table of display cases
    // ------------------------------------------------------------
    localparam int unsigned HOLD_N = 16;
    localparam int unsigned SCAN_N = 8;
    typedef struct packed {
        logic fmt;
        logic [2:0] pos;
        logic [6:0] code;
    } dsa_row_t;
    // latched count lands at 1230..1234: digits 1,2,3 then 0..4
    dsa_row_t rows [6] = '{
        '{1'b1, 3'h3, 7'h01}, '{1'b1, 3'h2, 7'h02}, '{1'b1, 3'h1, 7'h03},
        '{1'b0, 3'h3, 7'h06}, '{1'b0, 3'h2, 7'h5B}, '{1'b0, 3'h1, 7'h4F}};
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic trigger_i = 1'b0;
    logic fmt_bcd_i = 1'b1;
    logic osc_en = 1'b1;
    logic comparator_i;
    logic ctrl_a_o;
    logic ctrl_b_o;
    logic over_range_o;
    logic result_strobe_o;
    logic hold_o;
    logic [4:0] digit_en_o;
    logic [6:0] code_o;
    logic sign_o;
    int bad_count = 0;
    int checks_done = 0;

    // clock at 10 MHz
    always #50 core_clk_i = ~core_clk_i;

    // design and front end
    dsa_sequencer #(.HOLD_PULSES(HOLD_N), .SCAN_DIV(SCAN_N)) dut (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .trigger_i(trigger_i),
        .comparator_i(comparator_i), .fmt_bcd_i(fmt_bcd_i),
        .ctrl_a_o(ctrl_a_o), .ctrl_b_o(ctrl_b_o),
        .over_range_o(over_range_o), .result_strobe_o(result_strobe_o),
        .hold_o(hold_o), .digit_en_o(digit_en_o), .code_o(code_o),
        .sign_o(sign_o));
    dsa_fe_model fe (
        .core_clk_i(core_clk_i), .ctrl_a_i(ctrl_a_o), .ctrl_b_i(ctrl_b_o),
        .positive_i(1'b1), .osc_en_i(osc_en), .ref_clocks_i(16'h099C),
        .comparator_o(comparator_i));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask : cyc

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    // watchdog sized above the single conversion walk
    initial begin
        repeat (100000) @(posedge core_clk_i);
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        logic [4:0] e;
        cyc(5);
        chk({ctrl_a_o, ctrl_b_o, hold_o, digit_en_o} === 8'h00, "reset");
        rst_n_i = 1'b1;
        cyc(1);
        chk(digit_en_o === 5'h01, "first digit after reset");
        $display("test reset done");
        // trigger low: counter stops at 20000 counts
        n = 1;
        while (hold_o !== 1'b1 && n < 41000) begin
            cyc(1);
            n++;
        end
        chk(n >= 39990 && n <= 40010, "hold entry time");
        chk({ctrl_a_o, ctrl_b_o} === 2'b00, "controls low in hold");
        // scan keeps running in hold, each digit SCAN_N clocks
        e = digit_en_o;
        while (digit_en_o === e) cyc(1);
        e = digit_en_o;
        n = 0;
        while (digit_en_o === e && n < 100) begin
            cyc(1);
            n++;
        end
        chk(n == SCAN_N, "digit slot length");
        chk($onehot(digit_en_o), "one digit enabled");
        cyc(200);
        chk(hold_o === 1'b1 && !ctrl_a_o && !ctrl_b_o, "hold kept");
        $display("test hold done");
        // resume: quiet comparator so the test is not a clear
        osc_en = 1'b0;
        cyc(10);
        trigger_i = 1'b1;
        n = 0;
        while (hold_o === 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        chk(n <= HOLD_N + 8, "hold release");
        osc_en = 1'b1;
        n = 0;
        while ({ctrl_a_o, ctrl_b_o} !== 2'b11 && n < 21000) begin
            cyc(1);
            n++;
        end
        chk(n >= 19990 && n <= 20010, "auto-zero end at 30000");
        n = 0;
        while ({ctrl_a_o, ctrl_b_o} === 2'b11 && n < 21000) begin
            cyc(1);
            n++;
        end
        chk(n == 20000, "input phase length");
        chk({ctrl_a_o, ctrl_b_o} === 2'b10, "positive reference");
        n = 0;
        while (result_strobe_o !== 1'b1 && n < 3000) begin
            cyc(1);
            n++;
        end
        chk(n < 3000, "result strobe seen");
        chk({ctrl_a_o, ctrl_b_o, over_range_o} === 3'b000, "crossing");
        cyc(1);
        chk(result_strobe_o === 1'b0, "strobe one cycle");
        $display("test conversion done");
        // display rows in both formats
        foreach (rows[i]) begin
            fmt_bcd_i = rows[i].fmt;
            cyc(SCAN_N * 12);
            n = 0;
            while (digit_en_o !== (5'h01 << rows[i].pos) && n < 100) begin
                cyc(1);
                n++;
            end
            chk(code_o === rows[i].code, "digit code");
        end
        fmt_bcd_i = 1'b1;
        cyc(SCAN_N * 12);
        while (digit_en_o !== 5'h01) cyc(1);
        chk(code_o[6:3] === 4'h0 && code_o[2:0] <= 3'h4, "least digit");
        while (digit_en_o !== 5'h10) cyc(1);
        chk(sign_o === 1'b1, "positive sign");
        $display("test display done");
        print_verdict();
    end
endmodule : tb
